// ---- logic/cs_consts.svh ----
// Purpose: constants for the CAN status and slot format block
// Assumes: bit n of a 16-bit register is printed as D(15-n)
// Notes: offsets are byte addresses on the plain register port
`ifndef CS_CONSTS_SVH
`define CS_CONSTS_SVH

// register addresses
`define CS_ADDR_STATUS 32'h0080_1002
`define CS_ADDR_FORMAT 32'h0080_1004
`define CS_ADDR_IRQ_STAT 32'h0080_1010
`define CS_ADDR_IRQ_MASK 32'h0080_1012

// reset values
`define CS_RST_STATUS 16'h0100
`define CS_RST_FORMAT 16'h0000
`define CS_RST_IRQ 4'h0

// status field positions (D1 is bit 14, D15 is bit 0)
`define CS_BIT_BUS_OFF 14
`define CS_BIT_ERR_PASSIVE 13
`define CS_BIT_BUS_ERR 12
`define CS_BIT_DBL_BUF 11
`define CS_BIT_LOOPBACK 9
`define CS_BIT_PROTO_RST 8
`define CS_BIT_RECEIVING 7
`define CS_BIT_TRANSMITTING 6
`define CS_BIT_RX_DONE 5
`define CS_BIT_TX_DONE 4
`define CS_SLOT_MSB 3
`define CS_SLOT_LSB 0

// interrupt event positions
`define CS_IRQ_BUS_ERR 0
`define CS_IRQ_RX_DONE 1
`define CS_IRQ_TX_DONE 2
`define CS_IRQ_BUS_OFF 3

// error counter limits
`define CS_TEC_BUS_OFF 9'h0ff
`define CS_ERR_PASSIVE 9'h07f

// recessive bits needed before joining the bus
`define CS_IDLE_BITS 4'hb

// double buffer slots
`define CS_DBL_SLOT_A 14
`define CS_DBL_SLOT_B 15

`endif

// ---- logic/cs_pkg.sv ----
// Purpose: types shared by the CAN status block
// Assumes: constants live in cs_consts.svh
// Notes: no numbers here, only types
`default_nettype none

package cs_pkg;

    // protocol unit events, each a one-cycle pulse
    typedef struct packed {
        logic bus_err;
        logic rx_ok;
        logic tx_ok;
        logic rx_role;
        logic tx_role;
        logic bus_idle;
        logic rx_store;
        logic rx_self;
        logic db_store;
    } cs_evt_s;

    // request bits held in the control register
    typedef struct packed {
        logic reset_request;
        logic forced_reset;
        logic loopback_request;
        logic double_buffer_request;
    } cs_ctrl_s;

    // protocol unit state, gray along reset, sync, run
    typedef enum logic [1:0] {
        ST_RESET = 2'h0,
        ST_SYNC = 2'h1,
        ST_RUN = 2'h3
    } cs_state_e;

endpackage

`default_nettype wire

// ---- logic/cs_idle_det.sv ----
// Purpose: count consecutive recessive bits on the bus
// Assumes: bit_tick pulses once per sampled bit
// Notes: saturates once the limit is reached
`default_nettype none
`include "cs_consts.svh"

module cs_idle_det (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic clear,
    // bus samples
    input wire logic bit_tick,
    input wire logic rx_bit,
    // result
    output logic idle_seen
);

    logic [3:0] count_r;
    logic [3:0] count_nxt;

    always_comb begin
        count_nxt = count_r;
        if (clear) begin
            count_nxt = 4'h0;
        end else if (bit_tick) begin
            // any dominant bit restarts the run
            if (!rx_bit) begin
                count_nxt = 4'h0;
            end else if (count_r != `CS_IDLE_BITS) begin
                count_nxt = count_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_r <= 4'h0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign idle_seen = (count_r == `CS_IDLE_BITS);

endmodule

`default_nettype wire

// ---- logic/cs_status.sv ----
// Purpose: CAN status register, per-slot id format and bus join control
// Assumes: protocol events are one-cycle pulses on clk
// Notes: read data appear one cycle after the read strobe
//
// Notes on behaviour
// - bus-off flag set when transmit errors pass 255, cleared on recovery
// - error-passive flag set when either counter passes 127 and the bus-off flag is not set
// - bus error flag set on any bus error, cleared by good frame
// - double buffer status needs request bit and slots 14, 15 receiving
// - loopback status follows the loopback request bit
// - protocol reset status high in reset, drops when request cleared
// - receiving flag while receiver, cleared on transmit start or idle
// - transmitting flag while transmitter, cleared on receive or idle
// - reception complete set on good receive, cleared on good transmit
// - transmission complete set on good transmit, cleared on good receive
// - completed slot field holds number of the finished slot
// - status bits are read only, writes do nothing
// - own looped frame: slot field shows sender, then zero
// - unassigned status bits read zero
// - one format bit per slot, one means extended identifiers
// - join the bus only after eleven recessive bits
// - double buffer stores alternate, slot 14 first
//
// Chosen here: the address-and-strobe port.
`default_nettype none
`include "cs_consts.svh"

module cs_status (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // error counters
    input wire logic [8:0] tx_err_count,
    input wire logic [8:0] rx_err_count,
    input wire logic bus_off_recover,
    // protocol events and slot numbers
    input wire cs_pkg::cs_evt_s proto_evt,
    input wire logic [3:0] tx_slot,
    input wire logic [3:0] rx_slot,
    // control register requests
    input wire cs_pkg::cs_ctrl_s ctrl,
    // slot state
    input wire logic [15:0] slot_rx_data_cfg,
    input wire logic [15:0] slot_req_pending,
    input wire logic tx_frame_active,
    // bus samples
    input wire logic bit_tick,
    input wire logic rx_bit,
    // block outputs
    output logic [15:0] slot_format,
    output logic protocol_reset_status,
    output logic bus_join,
    output logic db_slot_odd,
    output logic irq
);

    function automatic logic hit(input logic [31:0] a,
                                 input logic [31:0] off);
        hit = (a == off);
    endfunction

    // register port decode
    logic wr_format;
    logic wr_irq_stat;
    logic wr_irq_mask;

    assign wr_format = reg_wr && hit(reg_addr, `CS_ADDR_FORMAT);
    assign wr_irq_stat = reg_wr && hit(reg_addr, `CS_ADDR_IRQ_STAT);
    assign wr_irq_mask = reg_wr && hit(reg_addr, `CS_ADDR_IRQ_MASK);

    // protocol unit state
    cs_pkg::cs_state_e state_r;
    cs_pkg::cs_state_e state_nxt;
    logic idle_seen;
    logic rst_req_any;

    assign rst_req_any = ctrl.reset_request || ctrl.forced_reset;

    cs_idle_det u_idle (
        .clk(clk),
        .rst_n(rst_n),
        .clear(state_r != cs_pkg::ST_SYNC),
        .bit_tick(bit_tick),
        .rx_bit(rx_bit),
        .idle_seen(idle_seen)
    );

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            cs_pkg::ST_RESET: begin
                if (!rst_req_any) begin
                    state_nxt = cs_pkg::ST_SYNC;
                end
            end
            cs_pkg::ST_SYNC: begin
                if (rst_req_any) begin
                    state_nxt = cs_pkg::ST_RESET;
                end else if (idle_seen) begin
                    state_nxt = cs_pkg::ST_RUN;
                end
            end
            cs_pkg::ST_RUN: begin
                // a pending frame finishes before a soft reset bites
                if (ctrl.forced_reset) begin
                    state_nxt = cs_pkg::ST_RESET;
                end else if (ctrl.reset_request && !tx_frame_active) begin
                    state_nxt = cs_pkg::ST_RESET;
                end
            end
            default: begin
                state_nxt = cs_pkg::ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= cs_pkg::ST_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // status flags
    logic bus_off_r;
    logic bus_off_nxt;
    logic err_passive_r;
    logic err_passive_nxt;
    logic bus_err_r;
    logic bus_err_nxt;
    logic dbl_buf_r;
    logic dbl_buf_nxt;
    logic loopback_r;
    logic loopback_nxt;
    logic receiving_r;
    logic receiving_nxt;
    logic transmitting_r;
    logic transmitting_nxt;
    logic rx_done_r;
    logic rx_done_nxt;
    logic tx_done_r;
    logic tx_done_nxt;
    logic [3:0] slot_num_r;
    logic [3:0] slot_num_nxt;
    logic db_odd_r;
    logic db_odd_nxt;

    always_comb begin
        if (bus_off_r) begin
            bus_off_nxt = !bus_off_recover;
        end else begin
            bus_off_nxt = tx_err_count > `CS_TEC_BUS_OFF;
        end
        err_passive_nxt = !bus_off_nxt &&
            ((tx_err_count > `CS_ERR_PASSIVE) ||
             (rx_err_count > `CS_ERR_PASSIVE));
        bus_err_nxt = proto_evt.bus_err ||
            (bus_err_r && !(proto_evt.rx_ok || proto_evt.tx_ok));
        dbl_buf_nxt = ctrl.double_buffer_request &&
            slot_rx_data_cfg[`CS_DBL_SLOT_A] &&
            slot_rx_data_cfg[`CS_DBL_SLOT_B];
        loopback_nxt = ctrl.loopback_request;
        receiving_nxt = proto_evt.rx_role ||
            (receiving_r && !proto_evt.tx_role && !proto_evt.bus_idle);
        transmitting_nxt = proto_evt.tx_role ||
            (transmitting_r && !proto_evt.rx_role && !proto_evt.bus_idle);
        rx_done_nxt = proto_evt.rx_ok || (rx_done_r && !proto_evt.tx_ok);
        tx_done_nxt = proto_evt.tx_ok || (tx_done_r && !proto_evt.rx_ok);
        slot_num_nxt = slot_num_r;
        if (proto_evt.tx_ok) begin
            slot_num_nxt = tx_slot;
        end
        if (proto_evt.rx_store) begin
            if (proto_evt.rx_self && loopback_r) begin
                slot_num_nxt = 4'h0;
            end else begin
                slot_num_nxt = rx_slot;
            end
        end
        db_odd_nxt = db_odd_r;
        if (state_r == cs_pkg::ST_RESET) begin
            db_odd_nxt = 1'b0;
        end else if (dbl_buf_r && proto_evt.db_store) begin
            db_odd_nxt = !db_odd_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_off_r <= 1'b0;
            err_passive_r <= 1'b0;
            bus_err_r <= 1'b0;
            dbl_buf_r <= 1'b0;
            loopback_r <= 1'b0;
            receiving_r <= 1'b0;
            transmitting_r <= 1'b0;
            rx_done_r <= 1'b0;
            tx_done_r <= 1'b0;
            slot_num_r <= 4'h0;
            db_odd_r <= 1'b0;
        end else begin
            bus_off_r <= bus_off_nxt;
            err_passive_r <= err_passive_nxt;
            bus_err_r <= bus_err_nxt;
            dbl_buf_r <= dbl_buf_nxt;
            loopback_r <= loopback_nxt;
            receiving_r <= receiving_nxt;
            transmitting_r <= transmitting_nxt;
            rx_done_r <= rx_done_nxt;
            tx_done_r <= tx_done_nxt;
            slot_num_r <= slot_num_nxt;
            db_odd_r <= db_odd_nxt;
        end
    end

    // status word assembly
    logic [15:0] status_word;

    always_comb begin
        status_word = 16'h0000;
        status_word[`CS_BIT_BUS_OFF] = bus_off_r;
        status_word[`CS_BIT_ERR_PASSIVE] = err_passive_r;
        status_word[`CS_BIT_BUS_ERR] = bus_err_r;
        status_word[`CS_BIT_DBL_BUF] = dbl_buf_r;
        status_word[`CS_BIT_LOOPBACK] = loopback_r;
        status_word[`CS_BIT_PROTO_RST] = (state_r == cs_pkg::ST_RESET);
        status_word[`CS_BIT_RECEIVING] = receiving_r;
        status_word[`CS_BIT_TRANSMITTING] = transmitting_r;
        status_word[`CS_BIT_RX_DONE] = rx_done_r;
        status_word[`CS_BIT_TX_DONE] = tx_done_r;
        status_word[`CS_SLOT_MSB:`CS_SLOT_LSB] = slot_num_r;
    end

    // slot format register
    logic [15:0] format_r;
    logic [15:0] format_nxt;
    logic [15:0] format_word;

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_fmt
            always_comb begin
                format_nxt[gi] = format_r[gi];
                // slot 0 sits in the top bit of the register word
                format_word[15 - gi] = format_r[gi];
                if (wr_format && !slot_req_pending[gi]) begin
                    format_nxt[gi] = reg_wdata[15 - gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            format_r <= `CS_RST_FORMAT;
        end else begin
            format_r <= format_nxt;
        end
    end

    // interrupt status and mask
    logic [3:0] irq_stat_r;
    logic [3:0] irq_stat_nxt;
    logic [3:0] irq_mask_r;
    logic [3:0] irq_mask_nxt;
    logic [3:0] irq_evt;
    logic bus_off_rise;

    assign bus_off_rise = bus_off_nxt && !bus_off_r;

    always_comb begin
        irq_evt = 4'h0;
        irq_evt[`CS_IRQ_BUS_ERR] = proto_evt.bus_err;
        irq_evt[`CS_IRQ_RX_DONE] = proto_evt.rx_ok;
        irq_evt[`CS_IRQ_TX_DONE] = proto_evt.tx_ok;
        irq_evt[`CS_IRQ_BUS_OFF] = bus_off_rise;
        // a new event beats a one written in the same cycle
        irq_stat_nxt = irq_stat_r | irq_evt;
        if (wr_irq_stat) begin
            irq_stat_nxt = (irq_stat_r & ~reg_wdata[3:0]) | irq_evt;
        end
        irq_mask_nxt = irq_mask_r;
        if (wr_irq_mask) begin
            irq_mask_nxt = reg_wdata[3:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_stat_r <= `CS_RST_IRQ;
            irq_mask_r <= `CS_RST_IRQ;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
        end
    end

    // read path
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;

    always_comb begin
        rdata_nxt = 16'h0000;
        if (reg_rd) begin
            if (hit(reg_addr, `CS_ADDR_STATUS)) begin
                rdata_nxt = status_word;
            end else if (hit(reg_addr, `CS_ADDR_FORMAT)) begin
                rdata_nxt = format_word;
            end else if (hit(reg_addr, `CS_ADDR_IRQ_STAT)) begin
                rdata_nxt = {12'h000, irq_stat_r};
            end else if (hit(reg_addr, `CS_ADDR_IRQ_MASK)) begin
                rdata_nxt = {12'h000, irq_mask_r};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign slot_format = format_r;
    assign protocol_reset_status = (state_r == cs_pkg::ST_RESET);
    assign bus_join = (state_r == cs_pkg::ST_RUN);
    assign db_slot_odd = db_odd_r;
    assign irq = |(irq_stat_r & irq_mask_r);

endmodule

`default_nettype wire

// ---- tb/cs_bus_node.sv ----
// Purpose: bit-level view of the other nodes on the bus
// Assumes: one bit every four clocks while run is high
// Notes: n_tick counts bits sent since start
`default_nettype none

module cs_bus_node #(
    parameter int DOM_TICK = 2
) (
    // clock
    input wire logic clk,
    // control
    input wire logic run,
    // bus samples
    output logic bit_tick,
    output logic rx_bit,
    output logic [7:0] n_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div_r = 2'h0;
    logic edge_w;
    initial begin
        bit_tick = 1'b0;
        rx_bit = 1'b1;
        n_tick = 8'h00;
    end
    assign edge_w = run && div_r == 2'h3;
    always @(posedge clk) begin
        div_r <= run ? div_r + 2'h1 : 2'h0;
        bit_tick <= edge_w;
        n_tick <= n_tick + {7'h00, edge_w};
        rx_bit <= !(edge_w && n_tick == DOM_TICK);
    end
endmodule

`default_nettype wire

// ---- tb/cs_status_asserts.sv ----
// Purpose: port-level checks of the status block
// Assumes: one clock, synchronous active-low reset
// Notes: bound into every cs_status instance
`default_nettype none
`include "cs_consts.svh"

module cs_status_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // requests and slots
    input wire cs_pkg::cs_ctrl_s ctrl,
    input wire logic [15:0] slot_req_pending,
    // outputs
    input wire logic [15:0] slot_format,
    input wire logic protocol_reset_status,
    input wire logic bus_join
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // register word holds slot 0 in its top bit
    function automatic logic [15:0] flip16(input logic [15:0] v);
        for (int i = 0; i < 16; i++) begin
            flip16[i] = v[15 - i];
        end
    endfunction
    logic fmt_wr;
    logic map_rd;
    assign fmt_wr = reg_wr && reg_addr == `CS_ADDR_FORMAT;
    assign map_rd = reg_addr inside {`CS_ADDR_STATUS, `CS_ADDR_FORMAT,
        `CS_ADDR_IRQ_STAT, `CS_ADDR_IRQ_MASK};
    sequence s_rd(logic [31:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence s_released;
        protocol_reset_status ##1 !protocol_reset_status;
    endsequence
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    a_reserved_zero: assert property (s_rd(`CS_ADDR_STATUS) |=>
        !reg_rdata[15] && !reg_rdata[10])
        else $error("unassigned status bit reads one");
    a_unmapped_zero: assert property (reg_rd && !map_rd |=>
        reg_rdata == 16'h0000) else $error("unmapped read not zero");
    a_fmt_read: assert property (s_rd(`CS_ADDR_FORMAT) |=>
        reg_rdata == flip16($past(slot_format)))
        else $error("format read wrong");
    a_fmt_lock: assert property (fmt_wr |=> slot_format ==
        (flip16($past(reg_wdata)) & ~$past(slot_req_pending)
        | $past(slot_format) & $past(slot_req_pending)))
        else $error("format write wrong");
    a_prs_hold: assert property (protocol_reset_status &&
        (ctrl.reset_request || ctrl.forced_reset) |=> protocol_reset_status)
        else $error("reset status dropped with request set");
    a_forced_rst: assert property (ctrl.forced_reset |=>
        protocol_reset_status) else $error("forced reset not seen");
    a_join_wait: assert property (s_released |-> (!bus_join) [*8])
        else $error("joined the bus too early");
endmodule

bind cs_status cs_status_asserts u_chk (.*);

`default_nettype wire

// ---- tb/cs_status_test.sv ----
// Purpose: self-checking bench of the status block
// Assumes: register reads answer one cycle after the strobe
// Notes: events are single-cycle pulses from the bench
`default_nettype none
`include "cs_consts.svh"

module cs_status_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] ST = `CS_ADDR_STATUS;
    localparam logic [31:0] FMT = `CS_ADDR_FORMAT;
    localparam logic [31:0] IST = `CS_ADDR_IRQ_STAT;
    localparam logic [31:0] IMK = `CS_ADDR_IRQ_MASK;
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [31:0] reg_addr = 32'h0000_0000;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [8:0] tx_err_count = 9'h000, rx_err_count = 9'h000;
    logic bus_off_recover = 1'b0, tx_frame_active = 1'b0, run = 1'b0;
    cs_pkg::cs_evt_s proto_evt = 9'h000;
    cs_pkg::cs_ctrl_s ctrl = 4'h8;
    logic [3:0] tx_slot = 4'h0, rx_slot = 4'h0;
    logic [15:0] slot_rx_data_cfg = 16'h0000, slot_req_pending = 16'h0000;
    logic bit_tick, rx_bit, protocol_reset_status, bus_join;
    logic db_slot_odd, irq;
    logic [15:0] slot_format;
    logic [7:0] n_tick;
    int n_mismatch = 0, samples_checked = 0, cyc = 0;

    cs_status uut (.*);
    cs_bus_node #(.DOM_TICK(2)) node (.clk(clk), .run(run),
        .bit_tick(bit_tick), .rx_bit(rx_bit), .n_tick(n_tick));

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // a hang ends in the same report
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            give_verdict;
        end
    end

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read and compare the bits picked by m
    task automatic chk(input logic [31:0] a, input logic [15:0] m,
        input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        cmp(reg_rdata & m, e);
    endtask
    task automatic ev(input logic [8:0] e);
        @(posedge clk);
        proto_evt <= e;
        @(posedge clk);
        proto_evt <= 9'h000;
    endtask

    initial begin
        tick(6);
        rst_n <= 1'b1;
        chk(ST, 16'hffff, 16'h0100);
        wr(ST, 16'hffff);
        chk(ST, 16'hffff, 16'h0100);
        chk(FMT, 16'hffff, 16'h0000);
        chk(IMK, 16'hffff, 16'h0000);
        chk(32'h0080_1000, 16'hffff, 16'h0000);
        slot_req_pending <= 16'h00f0;
        wr(FMT, 16'hffff);
        chk(FMT, 16'hffff, 16'hf0ff);
        cmp(slot_format, 16'hff0f);
        slot_req_pending <= 16'h0000;
        wr(FMT, 16'h8001);
        chk(FMT, 16'hffff, 16'h8001);
        // leaving reset, then eleven recessive bits after one dominant
        ctrl <= 4'h0;
        run <= 1'b1;
        chk(ST, 16'h0100, 16'h0000);
        for (int i = 0; i < 200 && n_tick != 8'h0e; i++) @(posedge clk);
        cmp(16'(bus_join), 16'h0000);
        tick(4);
        cmp(16'(bus_join), 16'h0001);
        ev(9'h020);
        chk(ST, 16'h00c0, 16'h0080);
        ev(9'h010);
        chk(ST, 16'h00c0, 16'h0040);
        ev(9'h008);
        chk(ST, 16'h00c0, 16'h0000);
        ev(9'h100);
        chk(ST, 16'h1000, 16'h1000);
        tx_slot <= 4'h5;
        ev(9'h040);
        chk(ST, 16'h103f, 16'h0015);
        rx_slot <= 4'hf;
        ev(9'h084);
        chk(ST, 16'h003f, 16'h002f);
        ctrl <= 4'h2;
        chk(ST, 16'h0200, 16'h0200);
        tx_slot <= 4'h3;
        ev(9'h040);
        chk(ST, 16'h000f, 16'h0003);
        rx_slot <= 4'h9;
        ev(9'h006);
        chk(ST, 16'h000f, 16'h0000);
        ctrl <= 4'h1;
        slot_rx_data_cfg <= 16'h4000;
        chk(ST, 16'h0a00, 16'h0000);
        slot_rx_data_cfg <= 16'hc000;
        chk(ST, 16'h0800, 16'h0800);
        cmp(16'(db_slot_odd), 16'h0000);
        ev(9'h001);
        tick(1);
        cmp(16'(db_slot_odd), 16'h0001);
        ev(9'h001);
        tick(1);
        cmp(16'(db_slot_odd), 16'h0000);
        ctrl <= 4'h0;
        chk(ST, 16'h0800, 16'h0000);
        rx_err_count <= 9'h080;
        chk(ST, 16'h6000, 16'h2000);
        rx_err_count <= 9'h000;
        tx_err_count <= 9'h100;
        chk(ST, 16'h6000, 16'h4000);
        tx_err_count <= 9'h000;
        bus_off_recover <= 1'b1;
        tick(1);
        bus_off_recover <= 1'b0;
        chk(ST, 16'h6000, 16'h0000);
        // interrupt: raise, mask, clear
        wr(IST, 16'h000f);
        wr(IMK, 16'h0001);
        tick(1);
        cmp(16'(irq), 16'h0000);
        ev(9'h100);
        tick(1);
        cmp(16'(irq), 16'h0001);
        wr(IMK, 16'h0000);
        tick(1);
        cmp(16'(irq), 16'h0000);
        wr(IST, 16'h0001);
        wr(IMK, 16'h0001);
        tick(1);
        cmp(16'(irq), 16'h0000);
        // a soft reset waits for the frame on the wire, a forced one not
        tx_frame_active <= 1'b1;
        ctrl <= 4'h8;
        tick(3);
        cmp(16'(bus_join), 16'h0001);
        ctrl <= 4'hc;
        tick(2);
        cmp(16'(protocol_reset_status), 16'h0001);
        cmp(16'(bus_join), 16'h0000);
        tick(1);
        give_verdict;
    end
endmodule

`default_nettype wire
